// File: pra_defines.vh
`ifndef PRA_DEFINES_VH
`define PRA_DEFINES_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PRA_A_CMD    4'h0
`define PRA_A_RSP    4'h1
`define PRA_A_STAT   4'h2
`define PRA_A_ALARM  4'h3
`define PRA_A_RELAY  4'h4
`define PRA_A_ENA    4'h5
`define PRA_A_AOCFG  4'h6
`define PRA_A_AOVAL  4'h7
// ----------------------------------------
// Characters
// ----------------------------------------
`define PRA_C_AT     8'h40
`define PRA_C_COLON  8'h3a
`define PRA_C_ENTER  8'h0d
`define PRA_C_0      8'h30
`define PRA_C_1      8'h31
`define PRA_C_2      8'h32
`define PRA_C_3      8'h33
`define PRA_C_4      8'h34
`define PRA_C_6      8'h36
`define PRA_C_7      8'h37
`define PRA_C_9      8'h39
`define PRA_C_A      8'h41
`define PRA_C_B      8'h42
`define PRA_C_D      8'h44
`define PRA_C_E      8'h45
`define PRA_C_L      8'h4c
`define PRA_C_N      8'h4e
`define PRA_C_O      8'h4f
`define PRA_C_P      8'h50
`define PRA_C_S      8'h53
`define PRA_C_X      8'h58
`define PRA_C_QUERY  8'h3f
`define PRA_C_PLUS   8'h2b
`define PRA_C_MINUS  8'h2d
`define PRA_C_DOT    8'h2e
// ----------------------------------------
// Limits and defaults (pressure values in thousandths, hysteresis in percent)
// ----------------------------------------
`define PRA_TRIP_MAX 32'h05f5e100
`define PRA_HYST_MAX 4'ha
`define PRA_FS_MAX   32'h000f4240
`define PRA_SP_MAX   32'h00002904
`define PRA_SP_HI    32'h00002710
`define PRA_SP_DFLT  32'h00001388
`define PRA_INT_MAX  32'h000f4240
`define PRA_MILLI    32'h000003e8
`define PRA_PCT      40'h0000000064
`define PRA_RST_TRIP 32'h00000000
`define PRA_RST_HYST 4'ha
`define PRA_RST_CHAN 4'h1
`define PRA_RST_ACT  1'b1
`define PRA_RST_AOV  32'h000f4240
// ----------------------------------------
// Analog output scaling modes
// ----------------------------------------
`define PRA_M_LIN    2'h0
`define PRA_M_LOG    2'h1
`define PRA_M_SP     2'h2
`endif

// File: pra_alarm_eval.v
`include "pra_defines.vh"
module pra_alarm_eval #(
  parameter PW = 32
) (
  input  wire          mclk,        // System clock
  input  wire          rst_n,       // Async reset, active low
  input  wire          enable,      // Alarm enabled
  input  wire          idleAct,     // Idle polarity: 1 actuated
  input  wire [PW-1:0] trip,        // Trip point, signed
  input  wire [3:0]    hyst,        // Hysteresis percent
  input  wire [3:0]    chanSel,     // Bound input channel
  input  wire          sampleValid, // New sample strobe
  input  wire [3:0]    sampleChan,  // Sample channel
  input  wire [PW-1:0] samplePress, // Sample pressure, signed
  output reg           alarm,       // Alarm condition
  output reg           relay        // Relay drive
);
  wire [PW:0]   diff   = {samplePress[PW-1], samplePress} - {trip[PW-1], trip};
  wire [PW-1:0] absTrp = trip[PW-1] ? (~trip + 1'b1) : trip;
  wire [PW+7:0] lhs    = {{7{diff[PW]}}, diff} * `PRA_PCT;
  // Band is hyst percent of the trip magnitude, scaled by 100 on both sides
  wire [PW+7:0] rhs    = {8'h00, absTrp} * {{(PW+4){1'b0}}, hyst};
  wire          above  = $signed(lhs) > $signed(rhs);
  wire          below  = $signed(lhs) < -$signed(rhs);
  reg           alarmD;

  always @*
  begin
    alarmD = alarm;
    if (!enable)
      alarmD = 1'b0;
    else if (sampleValid && sampleChan == chanSel)
    begin
      if (above)
        alarmD = 1'b1;
      else if (below)
        alarmD = 1'b0;
    end
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarm <= 1'b0;
      relay <= `PRA_RST_ACT;
    end
    else
    begin
      alarm <= alarmD;
      relay <= idleAct ^ alarmD;
    end
  end
endmodule

// File: pra_relay_ctrl.v
`include "pra_defines.vh"
module pra_relay_ctrl #(
  parameter NREL = 16,
  parameter NCH  = 10,
  parameter PW   = 32
) (
  input  wire          mclk,        // 20 MHz clock
  input  wire          rst_n,       // Async reset, active low
  input  wire [3:0]    addr,        // Register address
  input  wire [7:0]    wrData,      // Write data
  input  wire          wrStb,       // Write strobe
  input  wire          rdStb,       // Read strobe
  output reg  [31:0]   rdData_q,    // Read data, cycle after strobe
  input  wire [NCH-1:0] chanOn,     // Channel on flags
  input  wire          sampleValid, // New pressure sample
  input  wire [3:0]    sampleChan,  // Sample channel 0-9
  input  wire [PW-1:0] samplePress, // Pressure, signed milli-Torr
  output wire [NREL-1:0] relay_q,   // Relay drives
  output reg  [1:0]    aoMode_q,    // Analog scaling mode
  output reg  [3:0]    aoDecades_q, // Log decades
  output reg  [3:0]    aoChan_q,    // Analog input channel
  output reg  [31:0]   aoValue_q    // Full scale or set-point, thousandths
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function isDig;
    input [7:0] c;
    isDig = (c >= `PRA_C_0) && (c <= `PRA_C_9);
  endfunction

  function isLet;
    input [7:0] c;
    isLet = (c >= `PRA_C_A) && (c <= `PRA_C_P);
  endfunction

  localparam S_IDLE = 3'b001;
  localparam S_HDR  = 3'b010;
  localparam S_DATA = 3'b100;

  // ----------------------------------------
  // Configuration storage
  // ----------------------------------------
  reg [NREL-1:0] alarmEn_q;
  reg [NREL-1:0] idleAct_q;
  reg [PW-1:0]   trip_q [0:NREL-1];
  reg [3:0]      hyst_q [0:NREL-1];
  reg [3:0]      aChan_q [0:NREL-1];
  reg [4:0]      slotA_q [0:NCH-1];
  reg [4:0]      slotB_q [0:NCH-1];
  wire [NREL-1:0] alarm;

  // ----------------------------------------
  // Parser state
  // ----------------------------------------
  reg [2:0]  st_q;
  reg [7:0]  h0_q, h1_q, h2_q, h3_q;
  reg [2:0]  hCnt_q;
  reg [7:0]  d0_q, d1_q, d2_q;
  reg [3:0]  dCnt_q;
  reg        neg_q, dot_q, bad_q, anyDig_q;
  reg [1:0]  fCnt_q;
  reg [31:0] intAcc_q;
  reg [9:0]  frac_q;
  reg [7:0]  rsp_q;
  reg        rspV_q;
  reg        ok_q, err_q;
  reg        hdrOvf_q;

  wire       cmdWr = wrStb && (addr == `PRA_A_CMD);
  wire [7:0] ch    = wrData;
  wire       exec  = cmdWr && (ch == `PRA_C_ENTER) && (st_q == S_DATA);

  // Numeric value in thousandths
  wire [31:0] fracS = (fCnt_q == 2'd1) ? {22'h0, frac_q} * 32'd100 :
                      (fCnt_q == 2'd2) ? {22'h0, frac_q} * 32'd10 :
                                         {22'h0, frac_q};
  wire [31:0] magM  = intAcc_q * `PRA_MILLI + fracS;
  wire [31:0] valM  = neg_q ? (~magM + 1'b1) : magM;
  wire        numOk = anyDig_q && !bad_q;
  wire        fracZ = (frac_q == 10'h0);

  // Header decode
  wire       hdr4   = (hCnt_q == 3'd4) && !hdrOvf_q;
  wire       isAl   = hdr4 && h0_q == `PRA_C_0 && h1_q == `PRA_C_1;
  wire [3:0] aIdx   = h3_q[3:0] - 4'h1;
  wire       aLetOk = isLet(h3_q);
  wire [3:0] aCh    = aChan_q[aIdx];
  wire       chOnA  = (aCh < NCH) ? chanOn[aCh] : 1'b0;
  wire       isSlot = hdr4 && h0_q == `PRA_C_0 && h1_q == `PRA_C_6 &&
                      (h2_q == `PRA_C_A || h2_q == `PRA_C_B);
  wire [3:0] sCh    = h3_q[3:0];
  // Scaling select also comes with a three-character header, no output number
  wire       hdr3   = (hCnt_q == 3'd3) && !hdrOvf_q;
  wire       isAo   = h0_q == `PRA_C_0 && h1_q == `PRA_C_7 &&
                      ((hdr4 && h3_q == `PRA_C_1) ||
                       (hdr3 && h2_q == `PRA_C_1));
  wire       oneCh  = (dCnt_q == 4'd1);
  wire [3:0] dIdx   = d0_q[3:0] - 4'h1;
  wire       spHi   = $signed(valM) > $signed(`PRA_SP_HI);
  wire       spIn   = $signed(valM) <= $signed(`PRA_SP_MAX) &&
                      $signed(valM) >= -$signed(`PRA_SP_MAX);
  wire       trIn   = $signed(valM) <= $signed(`PRA_TRIP_MAX) &&
                      $signed(valM) >= -$signed(`PRA_TRIP_MAX);
  wire       fsIn   = !neg_q && magM != 32'h0 && magM <= `PRA_FS_MAX;

  reg [4:0]  slotRd;
  always @*
  begin
    slotRd = 5'h0;
    if (sCh < NCH)
      slotRd = (h2_q == `PRA_C_A) ? slotA_q[sCh] : slotB_q[sCh];
  end

  // ----------------------------------------
  // Command acceptance
  // ----------------------------------------
  reg accept;
  always @*
  begin
    accept = 1'b0;
    if (isAl && aLetOk && chOnA)
    begin
      case (h2_q)
        `PRA_C_1: accept = oneCh && (d0_q == `PRA_C_E || d0_q == `PRA_C_D);
        `PRA_C_2: accept = numOk && trIn;
        `PRA_C_3: accept = numOk && !neg_q && fracZ &&
                           intAcc_q <= {28'h0, `PRA_HYST_MAX};
        `PRA_C_4: accept = oneCh && (d0_q == `PRA_C_A || d0_q == `PRA_C_D);
        default:  accept = 1'b0;
      endcase
    end
    else if (isSlot && isDig(h3_q))
      accept = oneCh && (isLet(d0_q) || d0_q == `PRA_C_QUERY);
    else if (isAo)
    begin
      case (h2_q)
        `PRA_C_1: accept = (dCnt_q == 4'd2 && d0_q == `PRA_C_L &&
                            d1_q == `PRA_C_N) ||
                           (dCnt_q == 4'd2 && d0_q == `PRA_C_S &&
                            d1_q == `PRA_C_P) ||
                           (dCnt_q == 4'd3 && d0_q == `PRA_C_L &&
                            d1_q == `PRA_C_O && d2_q >= `PRA_C_1 &&
                            d2_q <= `PRA_C_9);
        `PRA_C_2: accept = oneCh && isDig(d0_q);
        `PRA_C_3: accept = numOk && ((aoMode_q == `PRA_M_SP) ? spIn : fsIn);
        default:  accept = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Parser and configuration update
  // ----------------------------------------
  integer i;
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q        <= S_IDLE;
      h0_q        <= 8'h00;
      h1_q        <= 8'h00;
      h2_q        <= 8'h00;
      h3_q        <= 8'h00;
      hCnt_q      <= 3'h0;
      hdrOvf_q    <= 1'b0;
      d0_q        <= 8'h00;
      d1_q        <= 8'h00;
      d2_q        <= 8'h00;
      dCnt_q      <= 4'h0;
      neg_q       <= 1'b0;
      dot_q       <= 1'b0;
      bad_q       <= 1'b0;
      anyDig_q    <= 1'b0;
      fCnt_q      <= 2'h0;
      intAcc_q    <= 32'h0;
      frac_q      <= 10'h0;
      rsp_q       <= 8'h00;
      rspV_q      <= 1'b0;
      ok_q        <= 1'b0;
      err_q       <= 1'b0;
      alarmEn_q   <= {NREL{1'b0}};
      idleAct_q   <= {NREL{`PRA_RST_ACT}};
      aoMode_q    <= `PRA_M_LIN;
      aoDecades_q <= 4'h1;
      aoChan_q    <= `PRA_RST_CHAN;
      aoValue_q   <= `PRA_RST_AOV;
      for (i = 0; i < NREL; i = i + 1)
      begin
        trip_q[i]  <= `PRA_RST_TRIP;
        hyst_q[i]  <= `PRA_RST_HYST;
        aChan_q[i] <= `PRA_RST_CHAN;
      end
      for (i = 0; i < NCH; i = i + 1)
      begin
        slotA_q[i] <= 5'h0;
        slotB_q[i] <= 5'h0;
      end
    end
    else
    begin
      if (rdStb && addr == `PRA_A_RSP)
        rspV_q <= 1'b0;
      if (cmdWr)
      begin
        if (ch == `PRA_C_AT)
        begin
          st_q     <= S_HDR;
          hCnt_q   <= 3'h0;
          hdrOvf_q <= 1'b0;
        end
        else
        begin
          case (st_q)
            S_IDLE:
              st_q <= S_IDLE;
            S_HDR:
              if (ch == `PRA_C_COLON)
              begin
                st_q     <= S_DATA;
                dCnt_q   <= 4'h0;
                neg_q    <= 1'b0;
                dot_q    <= 1'b0;
                bad_q    <= 1'b0;
                anyDig_q <= 1'b0;
                fCnt_q   <= 2'h0;
                intAcc_q <= 32'h0;
                frac_q   <= 10'h0;
              end
              else if (ch == `PRA_C_ENTER)
              begin
                st_q  <= S_IDLE;
                ok_q  <= 1'b0;
                err_q <= 1'b1;
              end
              else
              begin
                case (hCnt_q)
                  3'd0: h0_q <= ch;
                  3'd1: h1_q <= ch;
                  3'd2: h2_q <= ch;
                  3'd3: h3_q <= ch;
                  default: hdrOvf_q <= 1'b1;
                endcase
                if (hCnt_q != 3'd4)
                  hCnt_q <= hCnt_q + 3'd1;
              end
            S_DATA:
              if (ch == `PRA_C_ENTER)
              begin
                st_q  <= S_IDLE;
                ok_q  <= accept;
                err_q <= !accept;
              end
              else
              begin
                if (dCnt_q == 4'd0)
                  d0_q <= ch;
                if (dCnt_q == 4'd1)
                  d1_q <= ch;
                if (dCnt_q == 4'd2)
                  d2_q <= ch;
                if (dCnt_q != 4'hf)
                  dCnt_q <= dCnt_q + 4'd1;
                // Decimal number, up to three fraction digits
                if ((ch == `PRA_C_MINUS || ch == `PRA_C_PLUS) && dCnt_q == 4'd0)
                  neg_q <= (ch == `PRA_C_MINUS);
                else if (ch == `PRA_C_DOT && !dot_q)
                  dot_q <= 1'b1;
                else if (isDig(ch))
                begin
                  anyDig_q <= 1'b1;
                  if (dot_q)
                  begin
                    if (fCnt_q != 2'd3)
                    begin
                      frac_q <= frac_q * 10'd10 + {6'h0, ch[3:0]};
                      fCnt_q <= fCnt_q + 2'd1;
                    end
                  end
                  else if (intAcc_q > `PRA_INT_MAX)
                    bad_q <= 1'b1;
                  else
                    intAcc_q <= intAcc_q * 32'd10 + {28'h0, ch[3:0]};
                end
                else
                  bad_q <= 1'b1;
              end
            default:
              st_q <= S_IDLE;
          endcase
        end
      end

      if (exec && accept && isAl)
      begin
        case (h2_q)
          `PRA_C_1: alarmEn_q[aIdx] <= (d0_q == `PRA_C_E);
          `PRA_C_2: trip_q[aIdx]    <= valM;
          `PRA_C_3: hyst_q[aIdx]    <= intAcc_q[3:0];
          `PRA_C_4: idleAct_q[aIdx] <= (d0_q == `PRA_C_A);
          default:  trip_q[aIdx]    <= trip_q[aIdx];
        endcase
      end

      if (exec && accept && isSlot)
      begin
        if (d0_q == `PRA_C_QUERY)
        begin
          rsp_q  <= slotRd[4] ? (`PRA_C_A + {4'h0, slotRd[3:0]}) : `PRA_C_X;
          rspV_q <= 1'b1;
        end
        else
        begin
          if (h2_q == `PRA_C_A)
            slotA_q[sCh] <= {1'b1, dIdx};
          else
            slotB_q[sCh] <= {1'b1, dIdx};
          aChan_q[dIdx] <= sCh;
        end
      end

      if (exec && accept && isAo)
      begin
        case (h2_q)
          `PRA_C_1:
            if (d0_q == `PRA_C_S)
            begin
              aoMode_q <= `PRA_M_SP;
              if ($signed(aoValue_q) > $signed(`PRA_SP_HI))
                aoValue_q <= `PRA_SP_DFLT;
            end
            else if (d1_q == `PRA_C_N)
              aoMode_q <= `PRA_M_LIN;
            else
            begin
              aoMode_q    <= `PRA_M_LOG;
              aoDecades_q <= d2_q[3:0];
            end
          `PRA_C_2: aoChan_q <= d0_q[3:0];
          `PRA_C_3:
            if (aoMode_q == `PRA_M_SP && spHi)
              aoValue_q <= `PRA_SP_DFLT;
            else
              aoValue_q <= valM;
          default: aoChan_q <= aoChan_q;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Relay evaluation
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NREL; g = g + 1)
    begin : relayGen
      pra_alarm_eval #(
        .PW (PW)
      ) uEval (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .enable      (alarmEn_q[g]),
        .idleAct     (idleAct_q[g]),
        .trip        (trip_q[g]),
        .hyst        (hyst_q[g]),
        .chanSel     (aChan_q[g]),
        .sampleValid (sampleValid),
        .sampleChan  (sampleChan),
        .samplePress (samplePress),
        .alarm       (alarm[g]),
        .relay       (relay_q[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdData_q <= 32'h0;
    else if (rdStb)
    begin
      case (addr)
        `PRA_A_RSP:   rdData_q <= {23'h0, rspV_q, rsp_q};
        `PRA_A_STAT:  rdData_q <= {29'h0, (st_q != S_IDLE), err_q, ok_q};
        `PRA_A_ALARM: rdData_q <= {{(32-NREL){1'b0}}, alarm};
        `PRA_A_RELAY: rdData_q <= {{(32-NREL){1'b0}}, relay_q};
        `PRA_A_ENA:   rdData_q <= {{(32-NREL){1'b0}}, alarmEn_q};
        `PRA_A_AOCFG: rdData_q <= {22'h0, aoChan_q, aoDecades_q, aoMode_q};
        `PRA_A_AOVAL: rdData_q <= aoValue_q;
        default:      rdData_q <= 32'h0;
      endcase
    end
    else
      rdData_q <= 32'h0;
  end
endmodule

// File: pra_relay_ctrl_props.sv
module pra_relay_ctrl_props #(
  parameter NREL = 16,
  parameter NCH  = 10,
  parameter PW   = 32
) (
  input logic            mclk,        // Clock
  input logic            rst_n,       // Reset
  input logic [3:0]      addr,        // Address
  input logic [7:0]      wrData,      // Write data
  input logic            wrStb,       // Write strobe
  input logic            rdStb,       // Read strobe
  input logic [31:0]     rdData_q,    // Read data
  input logic [NCH-1:0]  chanOn,      // Channel on
  input logic            sampleValid, // Sample strobe
  input logic [3:0]      sampleChan,  // Sample channel
  input logic [PW-1:0]   samplePress, // Pressure
  input logic [NREL-1:0] relay_q,     // Relays
  input logic [1:0]      aoMode_q,    // Scaling mode
  input logic [3:0]      aoDecades_q, // Decades
  input logic [3:0]      aoChan_q,    // Analog channel
  input logic [31:0]     aoValue_q    // Analog value
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ----
  // Setup and relays move only for a cause; read data and setup values stay legal
  // ----
  sequence s_noEnter;
    !(wrStb && addr == 4'h0 && wrData == 8'h0d);
  endsequence
  sequence s_quiet;
    !wrStb ##1 (!wrStb && !sampleValid);
  endsequence
  property p_cfgHold;
    s_noEnter |=> $stable({aoMode_q, aoDecades_q, aoChan_q, aoValue_q});
  endproperty
  a_cfgHold: assert property (p_cfgHold) else $error("analog setup moved");
  property p_relayHold;
    s_quiet |=> $stable(relay_q);
  endproperty
  a_relayHold: assert property (p_relayHold) else $error("relay moved");
  property p_rdIdle;
    !rdStb |=> rdData_q == 32'h0;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside slot");
  property p_rdUnmap;
    rdStb && addr[3] |=> rdData_q == 32'h0;
  endproperty
  a_rdUnmap: assert property (p_rdUnmap) else $error("unmapped read not zero");
  property p_mode;
    aoMode_q != 2'h3;
  endproperty
  a_mode: assert property (p_mode) else $error("bad scaling mode");
  property p_dec;
    aoDecades_q >= 4'h1 && aoDecades_q <= 4'h9;
  endproperty
  a_dec: assert property (p_dec) else $error("bad decade count");
  property p_chan;
    aoChan_q <= 4'h9;
  endproperty
  a_chan: assert property (p_chan) else $error("bad analog channel");
  property p_sp;
    aoMode_q == 2'h2 |-> $signed(aoValue_q) <= 10000 && $signed(aoValue_q) >= -10500;
  endproperty
  a_sp: assert property (p_sp) else $error("set-point out of range");
endmodule
bind pra_relay_ctrl pra_relay_ctrl_props #(.NREL(NREL), .NCH(NCH), .PW(PW)) props_i (
  .mclk(mclk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
  .rdStb(rdStb), .rdData_q(rdData_q), .chanOn(chanOn), .sampleValid(sampleValid),
  .sampleChan(sampleChan), .samplePress(samplePress), .relay_q(relay_q),
  .aoMode_q(aoMode_q), .aoDecades_q(aoDecades_q), .aoChan_q(aoChan_q),
  .aoValue_q(aoValue_q)
);

// File: pra_host_model.sv
module pra_host_model (
  input  logic        mclk,     // Clock
  input  logic [31:0] rdData_q, // Read data
  output logic [3:0]  addr,     // Address
  output logic [7:0]  wrData,   // Write data
  output logic        wrStb,    // Write strobe
  output logic        rdStb     // Read strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap = 0;
  initial
  begin
    addr   = 4'h0;
    wrData = 8'h0;
    wrStb  = 1'b0;
    rdStb  = 1'b0;
  end
  // ----
  // One framed command, a character per write, idle cycles set by gap
  // ----
  task automatic cmd(input string h, input string d);
    string s;
    s = {"@", h, ":", d};
    for (int i = 0; i <= s.len(); i++)
    begin
      @(posedge mclk);
      addr   <= 4'h0;
      wrStb  <= 1'b1;
      wrData <= (i == s.len()) ? 8'h0d : s[i];
      repeat (gap)
      begin
        @(posedge mclk);
        wrStb  <= 1'b0;
        wrData <= ~wrData;
      end
    end
    @(posedge mclk);
    wrStb  <= 1'b0;
    wrData <= ~wrData;
    addr   <= ~addr;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    addr  <= ~a;
    #1;
    d = rdData_q;
  endtask
endmodule

// File: tb_pra_relay_ctrl.sv
`include "pra_defines.vh"
module tb_pra_relay_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst_n, wrStb, rdStb, sampleValid;
  logic [3:0]  addr, sampleChan, aoDecades_q, aoChan_q;
  logic [7:0]  wrData;
  logic [9:0]  chanOn;
  logic [15:0] relay_q;
  logic [1:0]  aoMode_q;
  logic [31:0] rdData_q, samplePress, aoValue_q, rdVal;
  int          errCount = 0;
  int          cmpCount = 0;
  string       hTab [9] = '{"012B", "012B", "013B", "013B", "011Q", "014B", "06AA", "0731", "0721"};
  string       dTab [9] = '{"100001", "-100000", "11", "0", "E", "X", "B", "1001", "A"};
  logic [1:0]  sTab [9] = '{2'h2, 2'h1, 2'h2, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
  pra_relay_ctrl pra_relay_ctrl_i (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData_q(rdData_q), .chanOn(chanOn), .sampleValid(sampleValid),
    .sampleChan(sampleChan), .samplePress(samplePress), .relay_q(relay_q),
    .aoMode_q(aoMode_q), .aoDecades_q(aoDecades_q), .aoChan_q(aoChan_q),
    .aoValue_q(aoValue_q)
  );
  pra_host_model pra_host_model_i (
    .mclk(mclk), .rdData_q(rdData_q), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb)
  );
  // ----
  // Clock, watchdog and helpers
  // ----
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    #500000;
    errCount++;
    printVerdict;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmpCount++;
    if (g !== e)
    begin
      errCount++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic printVerdict;
    if (errCount == 0 && cmpCount > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic rdChk(input string n, input logic [3:0] a, input logic [31:0] e);
    pra_host_model_i.rd(a, rdVal);
    chk(n, e, rdVal);
  endtask
  // Command, then its ok/err result
  task automatic cmd(input string h, input string d, input logic [1:0] st);
    pra_host_model_i.cmd(h, d);
    repeat (2) @(posedge mclk);
    rdChk({"status ", h}, `PRA_A_STAT, {30'h0, st});
  endtask
  task automatic smp(input logic [3:0] c, input logic [31:0] p, input logic [15:0] e);
    @(posedge mclk);
    sampleValid <= 1'b1;
    sampleChan  <= c;
    samplePress <= p;
    @(posedge mclk);
    sampleValid <= 1'b0;
    samplePress <= ~p;
    #1;
    chk("relays", {16'h0, e}, {16'h0, relay_q});
  endtask
  // ----
  // Tests
  // ----
  initial
  begin
    rst_n       = 1'b0;
    chanOn      = 10'h000;
    sampleValid = 1'b0;
    sampleChan  = 4'h0;
    samplePress = 32'h0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk("relays", 32'h0000ffff, {16'h0, relay_q});
    chk("aovalue", 32'h000f4240, aoValue_q);
    rdChk("enables", `PRA_A_ENA, 32'h0);
    rdChk("aocfg", `PRA_A_AOCFG, 32'h00000044);
    rdChk("unmapped", 4'h9, 32'h0);
    cmd("011A", "E", 2'h2);
    @(posedge mclk);
    chanOn <= 10'h3ff;
    cmd("011A", "E", 2'h1);
    rdChk("enables", `PRA_A_ENA, 32'h1);
    cmd("012A", "80", 2'h1);
    smp(4'h1, 32'd88000, 16'hffff);
    smp(4'h1, 32'd88001, 16'hfffe);
    rdChk("alarms", `PRA_A_ALARM, 32'h1);
    smp(4'h1, 32'd72000, 16'hfffe);
    smp(4'h1, 32'd71999, 16'hffff);
    cmd("013A", "1", 2'h1);
    cmd("012A", "760", 2'h1);
    smp(4'h1, 32'd767600, 16'hffff);
    smp(4'h1, 32'd767601, 16'hfffe);
    smp(4'h1, 32'd752400, 16'hfffe);
    smp(4'h1, 32'd752399, 16'hffff);
    cmd("014A", "D", 2'h1);
    smp(4'h1, 32'd700000, 16'hfffe);
    smp(4'h1, 32'd800000, 16'hffff);
    cmd("011A", "D", 2'h1);
    rdChk("relayreg", `PRA_A_RELAY, 32'h0000fffe);
    for (int i = 0; i < 9; i++)
      cmd(hTab[i], dTab[i], sTab[i]);
    chk("aovalue", 32'h000f4240, aoValue_q);
    cmd("06A5", "?", 2'h1);
    rdChk("answer", `PRA_A_RSP, 32'h00000158);
    cmd("06A5", "C", 2'h1);
    cmd("06A5", "?", 2'h1);
    rdChk("answer", `PRA_A_RSP, 32'h00000143);
    rdChk("answer", `PRA_A_RSP, 32'h00000043);
    cmd("06B5", "D", 2'h1);
    cmd("06B5", "?", 2'h1);
    rdChk("answer", `PRA_A_RSP, 32'h00000144);
    cmd("011C", "E", 2'h1);
    smp(4'h1, 32'd5000, 16'hfffe);
    smp(4'h5, 32'd1, 16'hfffa);
    cmd("0731", "0.001", 2'h1);
    chk("aovalue", 32'h1, aoValue_q);
    for (int d = 1; d <= 9; d++)
    begin
      cmd("071", $sformatf("LO%0d", d), 2'h1);
      chk("log", {26'h0, d[3:0], 2'h1}, {26'h0, aoDecades_q, aoMode_q});
    end
    cmd("071", "LN", 2'h1);
    chk("mode", 32'h0, {30'h0, aoMode_q});
    cmd("0731", "10.5", 2'h1);
    chk("aovalue", 32'd10500, aoValue_q);
    cmd("071", "SP", 2'h1);
    chk("mode", 32'h2, {30'h0, aoMode_q});
    chk("aovalue", 32'd5000, aoValue_q);
    cmd("0731", "-10.5", 2'h1);
    chk("aovalue", 32'hffffd6fc, aoValue_q);
    cmd("0731", "10.2", 2'h1);
    chk("aovalue", 32'd5000, aoValue_q);
    pra_host_model_i.gap = 3;
    cmd("0721", "0", 2'h1);
    chk("aochan", 32'h0, {28'h0, aoChan_q});
    printVerdict;
  end
endmodule
